// ### hw/sws_regs.svh
// Register map, field positions and timing constants for the stopwatch unit
`ifndef SWS_REGS_SVH
`define SWS_REGS_SVH

// Register indices as printed; byte address is four times the index
`define SWS_IDX_CONTROL      16'h5020
`define SWS_IDX_DIGIT_COUNT  16'h5021
`define SWS_IDX_IRQ_ENABLE   16'h5022
`define SWS_IDX_IRQ_PENDING  16'h5023
`define SWS_ADDR_W           18

// Field positions
`define SWS_RUN_BIT          0
`define SWS_CLEAR_BIT        4
`define SWS_SRC_100          0
`define SWS_SRC_10           1
`define SWS_SRC_1            2

// Reset values
`define SWS_CTRL_RST         1'b0
`define SWS_DIGIT_RST        4'h0
`define SWS_SRC_RST          3'h0

// Counting constants
`define SWS_DIGIT_MAX        4'h9
`define SWS_DIGIT_ONE        4'h1
`define SWS_TENTHS_SIX       4'h6
`define SWS_DIGIT_HALF       4'h5
`define SWS_FB_STEP          8'h64
`define SWS_FB_ZERO          8'h00

`endif

// ### hw/sws_pkg.sv
// Types shared by the stopwatch unit
package sws_pkg;

  // Bus slave state, one-hot
  typedef enum logic [1:0] {
    SWS_BUS_IDLE = 2'b01,
    SWS_BUS_ACK  = 2'b10
  } sws_bus_state_type;

  typedef logic [3:0] sws_digit_type;

endpackage : sws_pkg

// ### hw/sws_stopwatch_unit.sv
// Stopwatch unit: 256 Hz tick, feedback divider, two BCD digits, flags
//
// Summary of operation
// [R1] Run from 256 Hz tick input
// [R2] Feedback divider gives 2/3 tick spacing
// [R3] Hundredths digit advances per 100 Hz tick
// [R4] Tenths digit advances per 10 Hz tick
// [R5] Digits count 0..9; hundredths wrap advances tenths
// [R6] Control bit 4 write 1 clears digits
// [R7] Clear while running keeps counting from zero
// [R8] Reset clears digits, run, enables, flags
// [R9] Run bit 0 starts; stop keeps contents
// [R10] Run and clear together: clear then count
// [R11] Run change acts at next tick edge
// [R12] Stop performs one more count; run reads 1
// [R13] Software stops timer before sleep
// [R14] Software enables oscillator before use
// [R15] Signal falling edges set sticky flags
// [R16] One shared interrupt line out
// [R17] Request only for enabled flags
// [R18] Enable register bits 2..0, rest zero
// [R19] Write 1 clears a flag
// [R20] Flag register bits 2..0, rest zero
// [R21] Software clears flag before enabling
// [R22] Digit register read-only, tenths high nibble
// [R23] Software reads digits twice to confirm
// [R24] Reserved bits written zero, read zero
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "sws_regs.svh"

module sws_stopwatch_unit (
  input  wire logic                     clk,           // 10 MHz clock
  input  wire logic                     rst_n,         // Async reset, low
  input  wire logic                     tick_256,      // 256 Hz tick, pin
  input  wire logic [`SWS_ADDR_W-1:0]   address,       // Byte address
  input  wire logic                     read,          // Read request
  input  wire logic                     write,         // Write request
  input  wire logic [31:0]              writedata,     // Write data
  input  wire logic [3:0]               byteenable,    // Byte lanes
  output logic      [31:0]              readdata,      // Read data
  output logic                          waitrequest,   // Stall
  output logic                          irq_request,   // Shared request
  output logic [1:0]                    response       // 00 ok, 10 error
);
  import sws_pkg::*;

  localparam logic [`SWS_ADDR_W-1:0] A_CTRL =
    `SWS_ADDR_W'(`SWS_IDX_CONTROL * 4);
  localparam logic [`SWS_ADDR_W-1:0] A_CNT =
    `SWS_ADDR_W'(`SWS_IDX_DIGIT_COUNT * 4);
  localparam logic [`SWS_ADDR_W-1:0] A_MSK =
    `SWS_ADDR_W'(`SWS_IDX_IRQ_ENABLE * 4);
  localparam logic [`SWS_ADDR_W-1:0] A_FLG =
    `SWS_ADDR_W'(`SWS_IDX_IRQ_PENDING * 4);

  sws_bus_state_type bus_state_reg;
  logic [2:0]        tick_sync_reg;
  logic              tick_level_reg;
  logic              run_request_reg;
  logic              run_active_reg;
  logic              stop_pending_reg;
  logic              clear_req_reg;
  logic [7:0]        fb_cnt_reg;
  sws_digit_type     hundredths_digit_reg;
  sws_digit_type     tenths_digit_reg;
  logic [2:0]        irq_enable_reg;
  logic [2:0]        irq_flag_reg;
  logic              sig100_reg;
  logic              sig10_reg;
  logic              sig1_reg;

  logic tick_fall;
  logic fb_fire;
  logic [8:0] fb_sum;
  logic hund_wrap;
  logic tenth_wrap;
  logic wr_take;
  logic lane0;
  logic [2:0] set_evt;

  // Accept a write once, in the ack cycle, where waitrequest is low
  assign wr_take = (bus_state_reg == SWS_BUS_ACK) && write;
  assign lane0   = byteenable[0];

  // Tick filter: change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin // [R1]
    if (!rst_n) begin
      tick_sync_reg  <= 3'h0;
      tick_level_reg <= 1'b0;
    end else begin
      tick_sync_reg <= {tick_sync_reg[1:0], tick_256};
      if (tick_sync_reg[2] == tick_sync_reg[1]) begin
        tick_level_reg <= tick_sync_reg[2];
      end
    end
  end

  // Counting happens on the tick falling edge
  assign tick_fall = tick_level_reg &&
                     (tick_sync_reg[2] == tick_sync_reg[1]) &&
                     !tick_sync_reg[2];

  // Run control: start takes effect at the next tick fall, stop clears run at the second tick fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_request_reg  <= `SWS_CTRL_RST; // [R8]
      run_active_reg   <= `SWS_CTRL_RST;
      stop_pending_reg <= `SWS_CTRL_RST;
    end else begin
      if (wr_take && lane0 && (address == A_CTRL)) begin
        run_request_reg <= writedata[`SWS_RUN_BIT]; // [R9]
      end
      if (tick_fall) begin // [R11]
        if (run_request_reg) begin
          run_active_reg   <= 1'b1;
          stop_pending_reg <= 1'b0;
        end else if (run_active_reg && !stop_pending_reg) begin
          stop_pending_reg <= 1'b1; // [R12]
        end else begin
          run_active_reg   <= 1'b0;
          stop_pending_reg <= 1'b0;
        end
      end
    end
  end

  // Clear request waits for the tick so it meets the counting edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_req_reg <= 1'b0;
    end else if (wr_take && lane0 && (address == A_CTRL) &&
                 writedata[`SWS_CLEAR_BIT]) begin
      clear_req_reg <= 1'b1; // [R6]
    end else if (tick_fall) begin
      clear_req_reg <= 1'b0;
    end
  end

  // Feedback divider: accumulator adds 100 per tick, carry fires.
  // 100 carries per 256 ticks keep the 1 Hz output exact, spacing 2 or 3
  assign fb_sum  = {1'b0, fb_cnt_reg} + {1'b0, `SWS_FB_STEP};
  assign fb_fire = tick_fall && run_active_reg && fb_sum[8]; // [R2]

  always_ff @(posedge clk or negedge rst_n) begin // [R2]
    if (!rst_n) begin
      fb_cnt_reg <= `SWS_FB_ZERO;
    end else if (clear_req_reg && tick_fall) begin
      fb_cnt_reg <= `SWS_FB_ZERO;
    end else if (tick_fall && run_active_reg) begin
      fb_cnt_reg <= fb_sum[7:0]; // [R1] [R4]
    end
  end

  assign hund_wrap  = fb_fire && (hundredths_digit_reg == `SWS_DIGIT_MAX);
  assign tenth_wrap = hund_wrap && (tenths_digit_reg == `SWS_DIGIT_MAX);

  // BCD digits; clear wins and counting resumes from zero if running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hundredths_digit_reg <= `SWS_DIGIT_RST; // [R8]
      tenths_digit_reg     <= `SWS_DIGIT_RST;
    end else if (clear_req_reg && tick_fall) begin
      hundredths_digit_reg <= `SWS_DIGIT_RST; // [R7] [R10]
      tenths_digit_reg     <= `SWS_DIGIT_RST;
    end else if (fb_fire) begin
      hundredths_digit_reg <= hund_wrap ? `SWS_DIGIT_RST : // [R3] [R5]
                              hundredths_digit_reg + `SWS_DIGIT_ONE;
      if (hund_wrap) begin
        tenths_digit_reg <= tenth_wrap ? `SWS_DIGIT_RST : // [R4] [R5]
                            tenths_digit_reg + `SWS_DIGIT_ONE;
      end
    end
  end

  // Signals whose falling edges mark 100, 10 and 1 Hz events; only the 10 and 1 Hz ones are square
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sig100_reg <= 1'b0;
      sig10_reg  <= 1'b0;
      sig1_reg   <= 1'b0;
    end else begin
      sig100_reg <= fb_fire ? 1'b0 : (run_active_reg ? 1'b1 : sig100_reg);
      sig10_reg  <= (hundredths_digit_reg >= `SWS_DIGIT_HALF); // Falls at wrap
      sig1_reg   <= (tenths_digit_reg >= `SWS_DIGIT_HALF);
    end
  end

  // Events: falling edges of the three signals while counting
  assign set_evt[`SWS_SRC_100] = fb_fire;                       // [R15]
  assign set_evt[`SWS_SRC_10]  = hund_wrap;
  assign set_evt[`SWS_SRC_1]   = tenth_wrap;

  // Sticky flags; a set in the clear cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_reg <= `SWS_SRC_RST; // [R8]
    end else if (wr_take && lane0 && (address == A_FLG)) begin
      irq_flag_reg <= (irq_flag_reg & ~writedata[2:0]) | set_evt; // [R19]
    end else begin
      irq_flag_reg <= irq_flag_reg | set_evt; // [R15]
    end
  end

  // Enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_reg <= `SWS_SRC_RST; // [R8]
    end else if (wr_take && lane0 && (address == A_MSK)) begin
      irq_enable_reg <= writedata[2:0]; // [R18]
    end
  end

  // Shared request line, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= |(irq_flag_reg & irq_enable_reg); // [R16] [R17]
    end
  end

  // Avalon slave: one wait cycle, then answer with waitrequest low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= SWS_BUS_IDLE;
      waitrequest   <= 1'b1;
    end else begin
      case (bus_state_reg)
        SWS_BUS_IDLE: begin
          if (read || write) begin
            bus_state_reg <= SWS_BUS_ACK;
            waitrequest   <= 1'b0;
          end
        end
        SWS_BUS_ACK: begin
          bus_state_reg <= SWS_BUS_IDLE;
          waitrequest   <= 1'b1;
        end
        default: begin
          bus_state_reg <= SWS_BUS_IDLE;
          waitrequest   <= 1'b1;
        end
      endcase
    end
  end

  // Read data, reserved bits zero; unmapped reads zero with error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0;
      response <= 2'h0;
    end else if (bus_state_reg == SWS_BUS_IDLE && (read || write)) begin
      response <= 2'h0;
      readdata <= 32'h0;
      case (address)
        A_CTRL: readdata <= {31'h0, run_active_reg}; // [R12] [R24]
        A_CNT:  readdata <= {24'h0, tenths_digit_reg,
                             hundredths_digit_reg}; // [R22]
        A_MSK:  readdata <= {29'h0, irq_enable_reg}; // [R18]
        A_FLG:  readdata <= {29'h0, irq_flag_reg};   // [R20]
        default: response <= 2'h2;
      endcase
    end
  end

  // Digit stays within BCD range
  property p_digit_bcd;
    @(posedge clk) disable iff (!rst_n)
      hundredths_digit_reg <= `SWS_DIGIT_MAX &&
      tenths_digit_reg <= `SWS_DIGIT_MAX;
  endproperty
  a_digit_bcd: assert property (p_digit_bcd) // [R5]
    else $error("digit out of BCD range");

  // Hundredths wrap carries into tenths
  property p_carry;
    @(posedge clk) disable iff (!rst_n)
      (hund_wrap && !clear_req_reg && tenths_digit_reg != 4'h9) |=>
      tenths_digit_reg == $past(tenths_digit_reg) + 4'h1;
  endproperty
  a_carry: assert property (p_carry) // [R4]
    else $error("tenths did not advance on wrap");

  // Stopped hundredths digit holds
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (!run_active_reg && !clear_req_reg) |=> $stable(hundredths_digit_reg);
  endproperty
  a_hold: assert property (p_hold) // [R9]
    else $error("digit moved while stopped");

  // Clear zeroes digits at the tick
  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      (clear_req_reg && tick_fall) |=>
      hundredths_digit_reg == 4'h0 && tenths_digit_reg == 4'h0;
  endproperty
  a_clear: assert property (p_clear) // [R6]
    else $error("clear did not zero digits");

  // Event sets flag next cycle
  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
      fb_fire |=> irq_flag_reg[`SWS_SRC_100];
  endproperty
  a_flag_set: assert property (p_flag_set) // [R15]
    else $error("flag not set by event");

  // Request follows enabled flags
  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      (|(irq_flag_reg & irq_enable_reg)) |=> irq_request;
  endproperty
  a_irq: assert property (p_irq) // [R17]
    else $error("request missing");

  // No request without enabled flag
  property p_no_irq;
    @(posedge clk) disable iff (!rst_n)
      !(|(irq_flag_reg & irq_enable_reg)) |=> !irq_request;
  endproperty
  a_no_irq: assert property (p_no_irq) // [R16]
    else $error("spurious request");

  // Run never leaves active except at a tick fall
  property p_run_tick;
    @(posedge clk) disable iff (!rst_n)
      $changed(run_active_reg) |-> $past(tick_fall);
  endproperty
  a_run_tick: assert property (p_run_tick) // [R11]
    else $error("run changed off tick");

  // 100 Hz signal falls only with a divider output
  property p_sig100_fall;
    @(posedge clk) disable iff (!rst_n)
      $fell(sig100_reg) |-> $past(fb_fire);
  endproperty
  a_sig100_fall: assert property (p_sig100_fall) // [R15]
    else $error("100 Hz signal fell without event");

  // 10 Hz signal falls two cycles after a wrap or a clear
  property p_sig10_fall;
    @(posedge clk) disable iff (!rst_n)
      $fell(sig10_reg) |-> $past(hund_wrap || (clear_req_reg && tick_fall), 2);
  endproperty
  a_sig10_fall: assert property (p_sig10_fall) // [R15]
    else $error("10 Hz signal fell without wrap");

  // 1 Hz signal falls two cycles after a tenths wrap or a clear
  property p_sig1_fall;
    @(posedge clk) disable iff (!rst_n)
      $fell(sig1_reg) |-> $past(tenth_wrap || (clear_req_reg && tick_fall), 2);
  endproperty
  a_sig1_fall: assert property (p_sig1_fall) // [R15]
    else $error("1 Hz signal fell without wrap");

endmodule : sws_stopwatch_unit

// ### testbench/sws_tick_model.sv
// Tick source model: scaled oscillator divided down to the tick pin
`timescale 1ns/100ps
module sws_tick_model #(parameter int HALF = 8) (
  input  wire logic clk,      // Bench clock
  input  wire logic osc_on,   // Oscillator running
  output logic      tick_256, // Tick pin
  output int        falls     // Falling edges so far
);
  int cnt = 0;
  initial begin
    tick_256 = 1'b0;
    falls = 0;
  end
  // Square wave only while the oscillator runs, frozen at its current level otherwise
  always @(posedge clk) begin
    if (!osc_on) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      tick_256 <= !tick_256;
      if (tick_256) falls <= falls + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : sws_tick_model

// ### testbench/tb_top.sv
// Self-checking bench for the stopwatch unit
`timescale 1ns/100ps
`include "sws_regs.svh"
module tb_top;
  import sws_pkg::*;
  localparam logic [15:0] a_ctl = `SWS_IDX_CONTROL;
  localparam logic [15:0] a_cnt = `SWS_IDX_DIGIT_COUNT;
  localparam logic [15:0] a_msk = `SWS_IDX_IRQ_ENABLE;
  localparam logic [15:0] a_flg = `SWS_IDX_IRQ_PENDING;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        osc_on = 1'b0;
  logic        tick_256;
  logic [17:0] address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq_request;
  logic [1:0]  response;
  logic [31:0] rd;
  logic [31:0] d1;
  logic [1:0]  rs;
  int          falls;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          f0;
  int          m;

  // 10 MHz clock
  always #50 clk = ~clk;

  sws_stopwatch_unit DUT (.clk(clk), .rst_n(rst_n), .tick_256(tick_256),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
    .irq_request(irq_request), .response(response));
  sws_tick_model u_tick (.clk(clk), .osc_on(osc_on), .tick_256(tick_256),
    .falls(falls));

  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // Count match within two steps, modulo one full second
  task automatic chk_near(input logic [31:0] got, input int exp);
    int d;
    d = (got[7:4] * 10 + got[3:0] - exp + 200) % 100;
    cmp_count++;
    if ($isunknown(got) || got[31:8] !== 24'h0 || got[7:4] > 4'h9 ||
        got[3:0] > 4'h9 || (d > 2 && d < 98)) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near

  // Avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, wd};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    rs = response;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_errors++;
      report_and_stop();
    end
  endtask : bus

  task automatic wreg(input logic [15:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wreg

  task automatic rreg(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk_val(rd, exp);
  endtask : rreg

  // Returns just after the tick rises, clear of the next tick fall
  task automatic wait_falls(input int k);
    int t;
    int n;
    t = falls + k;
    n = 0;
    while (falls < t && n < 20 * k + 40) begin
      @(posedge clk);
      n++;
    end
    if (falls < t) begin
      n_errors++;
      report_and_stop();
    end
    repeat (8) @(posedge clk);
  endtask : wait_falls

  task automatic all_zero;
    for (int i = 0; i < 4; i++) begin
      rreg(a_ctl + 16'(i), 32'h0);
    end
  endtask : all_zero

  // Stop, see the extra count, then two matching reads of the digits
  task automatic stop_count;
    int f1;
    wreg(a_ctl, 8'h00);
    f1 = falls;
    rreg(a_ctl, 32'h1);
    wait_falls(3);
    rreg(a_ctl, 32'h0);
    bus(1'b0, a_cnt, 8'h00);
    d1 = rd;
    bus(1'b0, a_cnt, 8'h00);
    chk_val(rd, d1);
    chk_near(rd, ((f1 + 1 - f0) * 100 / 256) % 100);
  endtask : stop_count

  initial begin
    m = $urandom(32'h91DF);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    osc_on <= 1'b1;
    all_zero();
    wreg(16'h5024, 8'hFF);
    chk_val({30'h0, rs}, 32'h2);
    rreg(16'h5024, 32'h0);
    chk_val({30'h0, rs}, 32'h2);
    wreg(a_cnt, 8'h55);
    rreg(a_cnt, 32'h0);
    wreg(a_ctl, 8'h01);
    f0 = falls;
    wait_falls(30 + $urandom % 30);
    rreg(a_ctl, 32'h1);
    stop_count();
    wait_falls(20);
    rreg(a_cnt, d1);
    rreg(a_flg, 32'h3);
    chk_val({31'h0, irq_request}, 32'h0);
    repeat (4) begin
      m = $urandom % 8;
      wreg(a_msk, 8'(m));
      rreg(a_msk, 32'(m));
      repeat (2) @(posedge clk);
      chk_val({31'h0, irq_request}, 32'((m & 3) != 0));
    end
    wreg(a_flg, 8'h02);
    rreg(a_flg, 32'h1);
    wreg(a_flg, 8'h00);
    rreg(a_flg, 32'h1);
    wreg(a_flg, 8'h01);
    rreg(a_flg, 32'h0);
    wreg(a_ctl, 8'h10);
    wait_falls(2);
    rreg(a_cnt, 32'h0);
    rreg(a_ctl, 32'h0);
    wreg(a_msk, 8'h04);
    wreg(a_ctl, 8'h01);
    f0 = falls;
    wait_falls(256);
    stop_count();
    rreg(a_flg, 32'h7);
    chk_val({31'h0, irq_request}, 32'h1);
    wreg(a_ctl, 8'h11);
    wait_falls(15);
    wreg(a_ctl, 8'h11);
    f0 = falls;
    wait_falls(12);
    stop_count();
    wreg(a_ctl, 8'h01);
    wait_falls(5);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    all_zero();
    report_and_stop();
  end
endmodule : tb_top
